// ### slcd_pkg.sv
// Shared constants and carrier types of the segment LCD controller.
// Assumes a byte-wide special-function register port on one clock.
`default_nettype none
package slcd_pkg;
	localparam logic [7:0] ADDR_CONFIG = 8'h95;
	localparam logic [7:0] ADDR_CLOCK = 8'h96;
	localparam logic [7:0] ADDR_SEGLO = 8'h97;
	localparam logic [7:0] ADDR_PTR = 8'hAC;
	localparam logic [7:0] ADDR_DATA = 8'hAE;
	localparam logic [7:0] ADDR_SCREEN = 8'hB1;
	localparam logic [7:0] ADDR_SEGHI = 8'hED;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [7:0] SEGHI_MASK = 8'h0F;
	localparam logic [7:0] SEGLO_MASK = 8'hFC;
	localparam logic [7:0] CFG_MASK = 8'hBF;
	localparam int CFG_BIAS = 2;
	localparam int CFG_CLK = 3;
	localparam int CFG_BLINK = 5;
	localparam int CFG_CLR = 6;
	localparam int SCR_FREEZE = 0;
	localparam int SCR_SEL_LSB = 1;
	localparam int SCR_AUTO = 7;
	localparam int PTR_WR = 7;
	localparam int PTR_SCR_LSB = 4;
	localparam int NUM_SCREENS = 4;
	localparam int BYTES = 15;
	localparam int SEG_LINES = 29;
	localparam int COMS = 4;
	localparam int SEG_FIXED = 16;
	localparam int SEG_HI_BASE = 16;
	localparam int SEG_LO_BASE = 18;
	localparam int SEG_LO_TOP = 25;
	localparam int SEG_THIRD = 28;
	localparam int SEG_FOURTH = 27;
	localparam logic [1:0] MUX_3X = 2'h2;
	localparam logic [1:0] MUX_4X = 2'h3;
	localparam logic [1:0] BLK_SOFT_OFF = 2'h0;
	localparam logic [1:0] BLK_SOFT_ON = 2'h1;
	localparam logic [1:0] BLK_AUTO_FIFTH = 2'h2;
	localparam logic [1:0] BLK_AUTO = 2'h3;
	localparam int CLK_HZ = 100_000_000;
	localparam int FAST_HZ = 2048;
	localparam int SLOW_HZ = 128;
	localparam int FAST_CYC = CLK_HZ / FAST_HZ;
	localparam int SLOW_CYC = CLK_HZ / SLOW_HZ;
	// Base-clock ticks per half common step at 3x/4x; doubled for 2x
	localparam logic [15:0][7:0] FD_HALF_DEF = {8'h10, 8'h0F, 8'h0E,
		8'h0D, 8'h0C, 8'h0B, 8'h0A, 8'h09, 8'h08, 8'h07, 8'h06, 8'h05,
		8'h04, 8'h03, 8'h02, 8'h20};
	// 128 Hz ticks per blink half period; entry 4 is the fifth rate
	localparam logic [4:0][8:0] BLINK_DEF = {9'h040, 9'h100, 9'h080,
		9'h040, 9'h020};
	localparam logic [2:0] BLINK_FIFTH = 3'h4;
	typedef logic [BYTES-1:0][7:0] slcd_screen_t;
	typedef slcd_screen_t [NUM_SCREENS-1:0] slcd_cells_t;
	typedef enum logic {BLK_SHOW, BLK_HIDE} slcd_blink_t;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} slcd_sfr_t;
	typedef struct packed {
		logic en;
		logic [1:0] screen;
		logic [3:0] addr;
		logic [7:0] data;
	} slcd_mwr_t;
	typedef struct packed {
		logic [19:0] fast;
		logic [19:0] slow;
		logic [8:0] div;
	} slcd_tim_st_t;
	typedef struct packed {
		slcd_cells_t cells;
	} slcd_mem_st_t;
endpackage
`default_nettype wire

// ### slcd_timing.sv
// Base clock prescalers and half common step divider.
// Assumes clock_i at the package rate; outputs are one-cycle pulses.
`default_nettype none
module slcd_timing #(
	parameter int FAST_DIV = slcd_pkg::FAST_CYC,
	parameter int SLOW_DIV = slcd_pkg::SLOW_CYC,
	parameter logic [15:0][7:0] FD_HALF = slcd_pkg::FD_HALF_DEF
) (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic clock_pick_i,
	input wire logic [1:0] mux_i,
	input wire logic [3:0] fd_i,
	output logic half_tick_o,
	output logic slow_tick_o
);
	slcd_pkg::slcd_tim_st_t s_ff, nxt_s;
	logic fast_tick;
	logic base_tick;
	logic [8:0] limit;

	if (FAST_DIV < 2 || SLOW_DIV < 2 || SLOW_DIV >= (1 << 20)) begin : g_chk
		$error("slcd_timing: divider out of range");
	end

	always_comb begin
		nxt_s = s_ff;
		fast_tick = s_ff.fast == 20'(FAST_DIV - 1);
		slow_tick_o = s_ff.slow == 20'(SLOW_DIV - 1);
		nxt_s.fast = fast_tick ? '0 : s_ff.fast + 20'h1;
		nxt_s.slow = slow_tick_o ? '0 : s_ff.slow + 20'h1;
		base_tick = clock_pick_i ? slow_tick_o : fast_tick;
		// Two commons need twice the ticks per step
		limit = mux_i[1] ? {1'b0, FD_HALF[fd_i]} : {FD_HALF[fd_i], 1'b0};
		half_tick_o = base_tick && (s_ff.div >= limit - 9'h1);
		if (base_tick) begin
			nxt_s.div = half_tick_o ? '0 : s_ff.div + 9'h1;
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end
endmodule
`default_nettype wire

// ### slcd_mem.sv
// Four screens of segment data with clear, write and two read ports.
// Assumes the caller registers rd_data_o before software sees it.
`default_nettype none
module slcd_mem (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic clear_i,
	input wire slcd_pkg::slcd_mwr_t wr_i,
	input wire logic [1:0] rd_screen_i,
	input wire logic [3:0] rd_addr_i,
	input wire logic [1:0] disp_screen_i,
	output logic [7:0] rd_data_o,
	output slcd_pkg::slcd_screen_t screen_o
);
	slcd_pkg::slcd_mem_st_t s_ff, nxt_s;

	always_comb begin
		nxt_s = s_ff;
		if (clear_i) begin
			nxt_s.cells = '0;
		end else if (wr_i.en && wr_i.addr < 4'(slcd_pkg::BYTES)) begin
			nxt_s.cells[wr_i.screen][wr_i.addr] = wr_i.data;
		end
		rd_data_o = slcd_pkg::RESET_BYTE;
		if (rd_addr_i < 4'(slcd_pkg::BYTES)) begin
			rd_data_o = s_ff.cells[rd_screen_i][rd_addr_i];
		end
		screen_o = s_ff.cells[disp_screen_i];
	end

	// Only reset, clear and the write port touch contents
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (reset_i);
	mem_clear_a: assert property (clear_i |=> s_ff.cells == '0)
		else $error("memory not cleared");
	mem_write_a: assert property (wr_i.en && !clear_i &&
		wr_i.addr < 4'(slcd_pkg::BYTES) |=>
		s_ff.cells[$past(wr_i.screen)][$past(wr_i.addr)] ==
		$past(wr_i.data))
		else $error("memory write lost");
endmodule
`default_nettype wire

// ### slcd_ctrl.sv
// Segment LCD controller top: registers, pointer access, drive timing.
// Assumes a same-clock register port; a read answers one cycle later.
`default_nettype none
module slcd_ctrl #(
	parameter int FAST_DIV = slcd_pkg::FAST_CYC,
	parameter int SLOW_DIV = slcd_pkg::SLOW_CYC,
	parameter logic [15:0][7:0] FD_HALF = slcd_pkg::FD_HALF_DEF,
	parameter logic [4:0][8:0] BLINK_TICKS = slcd_pkg::BLINK_DEF
) (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire slcd_pkg::slcd_sfr_t sfr_i,
	output logic [7:0] sfr_rdata_o,
	output logic [slcd_pkg::SEG_LINES-1:0] seg_pin_lcd_o,
	output logic [slcd_pkg::COMS-1:0] com_pin_lcd_o,
	output logic [slcd_pkg::SEG_LINES-1:0] seg_drive_o,
	output logic [slcd_pkg::COMS-1:0] com_drive_o,
	output logic polarity_o,
	output logic bias_sel_o
);
	typedef struct packed {
		logic [7:0] cfg;
		logic [7:0] clk;
		logic [7:0] seglo;
		logic [7:0] seghi;
		logic [7:0] scr;
		logic [7:0] data;
		logic [7:0] ptr;
		logic [7:0] rdata;
		slcd_pkg::slcd_screen_t shown;
		logic [1:0] scroll_scr;
		logic [1:0] com_idx;
		logic half;
		logic pol;
		slcd_pkg::slcd_blink_t blink;
		logic [8:0] blink_cnt;
		logic [slcd_pkg::SEG_LINES-1:0] seg_drive;
		logic [slcd_pkg::COMS-1:0] com_drive;
	} slcd_ctrl_st_t;

	for (genvar i = 0; i < 16; i++) begin : g_chk
		if (FD_HALF[i] == 8'h00) begin : g_bad
			$error("slcd_ctrl: zero frame divider entry");
		end
	end

	slcd_ctrl_st_t s_ff, nxt_s;
	slcd_pkg::slcd_mwr_t mem_wr;
	slcd_pkg::slcd_screen_t mem_screen;
	logic [7:0] mem_rd;
	logic half_tick;
	logic slow_tick;
	logic ptr_wr;
	logic mem_clear;
	logic [1:0] mux;
	logic [1:0] mode;
	logic blink_en;
	logic scroll_on;
	logic auto_blink;
	logic disp_on;
	logic blink_exp;
	logic [8:0] blink_lim;
	logic [1:0] last_com;
	logic [1:0] disp_scr;
	logic [slcd_pkg::SEG_LINES-1:0] seg_en;
	logic [slcd_pkg::SEG_LINES-1:0] seg_bit;

	assign mux = s_ff.cfg[1:0];
	assign mode = s_ff.clk[7:6];
	assign blink_en = s_ff.cfg[slcd_pkg::CFG_BLINK];
	// Scrolling is not gated by any power state
	assign scroll_on = s_ff.scr[slcd_pkg::SCR_AUTO] && blink_en;
	assign auto_blink = mode[1];
	assign ptr_wr = sfr_i.wr && sfr_i.addr == slcd_pkg::ADDR_PTR;
	assign mem_clear = sfr_i.wr && sfr_i.addr == slcd_pkg::ADDR_CONFIG &&
		sfr_i.wdata[slcd_pkg::CFG_CLR];
	assign disp_scr = scroll_on ? s_ff.scroll_scr :
		s_ff.scr[slcd_pkg::SCR_SEL_LSB +: 2];

	always_comb begin
		mem_wr.en = ptr_wr && sfr_i.wdata[slcd_pkg::PTR_WR];
		mem_wr.screen = sfr_i.wdata[slcd_pkg::PTR_SCR_LSB +: 2];
		mem_wr.addr = sfr_i.wdata[3:0];
		// Data register was loaded by an earlier write
		mem_wr.data = s_ff.data;
	end

	slcd_mem u_mem (
		.clock_i(clock_i),
		.reset_i(reset_i),
		.clear_i(mem_clear),
		.wr_i(mem_wr),
		.rd_screen_i(sfr_i.wdata[slcd_pkg::PTR_SCR_LSB +: 2]),
		.rd_addr_i(sfr_i.wdata[3:0]),
		.disp_screen_i(disp_scr),
		.rd_data_o(mem_rd),
		.screen_o(mem_screen)
	);

	slcd_timing #(
		.FAST_DIV(FAST_DIV),
		.SLOW_DIV(SLOW_DIV),
		.FD_HALF(FD_HALF)
	) u_timing (
		.clock_i(clock_i),
		.reset_i(reset_i),
		.clock_pick_i(s_ff.cfg[slcd_pkg::CFG_CLK]),
		.mux_i(mux),
		.fd_i(s_ff.clk[3:0]),
		.half_tick_o(half_tick),
		.slow_tick_o(slow_tick)
	);

	// Pin ownership and data bit per segment line
	for (genvar k = 0; k < slcd_pkg::SEG_LINES; k++) begin : g_seg
		if (k < slcd_pkg::SEG_FIXED) begin : g_fix
			assign seg_en[k] = 1'b1;
		end else if (k < slcd_pkg::SEG_LO_BASE + 2) begin : g_hi
			assign seg_en[k] = s_ff.seghi[k - slcd_pkg::SEG_HI_BASE];
		end else if (k <= slcd_pkg::SEG_LO_TOP) begin : g_lo
			assign seg_en[k] = s_ff.seglo[k - slcd_pkg::SEG_LO_BASE];
		end else if (k == slcd_pkg::SEG_FOURTH) begin : g_27
			assign seg_en[k] = mux != slcd_pkg::MUX_4X;
		end else if (k == slcd_pkg::SEG_THIRD) begin : g_28
			assign seg_en[k] = !mux[1];
		end else begin : g_none
			assign seg_en[k] = 1'b0;
		end
		assign seg_bit[k] = s_ff.shown[k / 2][(k % 2) * 4 + s_ff.com_idx];
	end

	assign seg_pin_lcd_o = seg_en;
	assign com_pin_lcd_o = {mux == slcd_pkg::MUX_4X, mux[1], 2'b11};
	assign seg_drive_o = s_ff.seg_drive;
	assign com_drive_o = s_ff.com_drive;
	assign polarity_o = s_ff.pol;
	assign bias_sel_o = s_ff.cfg[slcd_pkg::CFG_BIAS];
	assign sfr_rdata_o = s_ff.rdata;

	always_comb begin
		last_com = mux[1] ? mux : 2'h1;
		blink_lim = BLINK_TICKS[mode == slcd_pkg::BLK_AUTO ?
			{1'b0, s_ff.clk[5:4]} : slcd_pkg::BLINK_FIFTH];
		blink_exp = slow_tick && s_ff.blink_cnt >= blink_lim - 9'h1;
		if (!blink_en || scroll_on) begin
			disp_on = 1'b1;
		end else if (auto_blink) begin
			disp_on = s_ff.blink == slcd_pkg::BLK_SHOW;
		end else begin
			disp_on = mode == slcd_pkg::BLK_SOFT_ON;
		end
	end

	always_comb begin
		nxt_s = s_ff;
		if (sfr_i.wr) begin
			case (sfr_i.addr)
				slcd_pkg::ADDR_CONFIG: begin
					nxt_s.cfg = sfr_i.wdata & slcd_pkg::CFG_MASK;
				end
				slcd_pkg::ADDR_CLOCK: begin
					nxt_s.clk = sfr_i.wdata;
				end
				slcd_pkg::ADDR_SEGLO: begin
					nxt_s.seglo = sfr_i.wdata & slcd_pkg::SEGLO_MASK;
				end
				slcd_pkg::ADDR_SEGHI: begin
					nxt_s.seghi = sfr_i.wdata & slcd_pkg::SEGHI_MASK;
				end
				slcd_pkg::ADDR_SCREEN: begin
					nxt_s.scr = sfr_i.wdata;
				end
				slcd_pkg::ADDR_DATA: begin
					nxt_s.data = sfr_i.wdata;
				end
				slcd_pkg::ADDR_PTR: begin
					nxt_s.ptr = sfr_i.wdata & 8'hBF;
					if (!sfr_i.wdata[slcd_pkg::PTR_WR]) begin
						nxt_s.data = mem_rd;
					end
				end
				default: begin
				end
			endcase
		end
		if (sfr_i.rd) begin
			case (sfr_i.addr)
				slcd_pkg::ADDR_CONFIG: nxt_s.rdata = s_ff.cfg;
				slcd_pkg::ADDR_CLOCK: nxt_s.rdata = s_ff.clk;
				slcd_pkg::ADDR_SEGLO: nxt_s.rdata = s_ff.seglo;
				slcd_pkg::ADDR_SEGHI: nxt_s.rdata = s_ff.seghi;
				slcd_pkg::ADDR_SCREEN: nxt_s.rdata = s_ff.scr;
				slcd_pkg::ADDR_DATA: nxt_s.rdata = s_ff.data;
				slcd_pkg::ADDR_PTR: nxt_s.rdata = s_ff.ptr;
				default: nxt_s.rdata = slcd_pkg::RESET_BYTE;
			endcase
		end
		// Displayed copy only follows memory while not frozen
		if (!s_ff.scr[slcd_pkg::SCR_FREEZE]) begin
			nxt_s.shown = mem_screen;
		end
		if (half_tick) begin
			nxt_s.pol = !s_ff.pol;
			nxt_s.half = !s_ff.half;
			if (s_ff.half) begin
				nxt_s.com_idx = s_ff.com_idx >= last_com ? 2'h0 :
					s_ff.com_idx + 2'h1;
			end
		end
		if (s_ff.com_idx > last_com) begin
			nxt_s.com_idx = 2'h0;
		end
		if (slow_tick) begin
			nxt_s.blink_cnt = blink_exp ? '0 : s_ff.blink_cnt + 9'h1;
		end
		if (blink_exp && blink_en && auto_blink) begin
			if (scroll_on) begin
				nxt_s.scroll_scr = s_ff.scroll_scr + 2'h1;
			end else begin
				case (s_ff.blink)
					slcd_pkg::BLK_SHOW: nxt_s.blink = slcd_pkg::BLK_HIDE;
					slcd_pkg::BLK_HIDE: nxt_s.blink = slcd_pkg::BLK_SHOW;
					default: nxt_s.blink = slcd_pkg::BLK_SHOW;
				endcase
			end
		end
		nxt_s.seg_drive = disp_on ? seg_bit & seg_en : '0;
		nxt_s.com_drive = 4'h1 << s_ff.com_idx;
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (reset_i);
	read_ptr_a: assert property (ptr_wr && !sfr_i.wdata[7] |=>
		s_ff.data == $past(mem_rd))
		else $error("pointer read not loaded");
	data_port_a: assert property (sfr_i.wr &&
		sfr_i.addr == slcd_pkg::ADDR_DATA |=>
		s_ff.data == $past(sfr_i.wdata))
		else $error("data port mismatch");
	data_read_a: assert property (sfr_i.rd && !sfr_i.wr &&
		sfr_i.addr == slcd_pkg::ADDR_DATA |=>
		sfr_rdata_o == $past(s_ff.data))
		else $error("data port read mismatch");
	freeze_hold_a: assert property (s_ff.scr[0] && $past(s_ff.scr[0]) &&
		!$past(reset_i) |-> $stable(s_ff.shown))
		else $error("frozen image changed");
	refresh_a: assert property (!s_ff.scr[0] |=>
		s_ff.shown == $past(mem_screen))
		else $error("image not refreshed");
	seg_mask_a: assert property (s_ff.seglo[1:0] == 2'h0 &&
		s_ff.seghi[7:4] == 4'h0)
		else $error("reserved enable bits set");
	low_seg_a: assert property (&seg_pin_lcd_o[15:0] &&
		seg_pin_lcd_o[19:16] == s_ff.seghi[3:0])
		else $error("segment enable wrong");
	com_pins_a: assert property (mux == slcd_pkg::MUX_4X |->
		com_pin_lcd_o == 4'hF && !seg_pin_lcd_o[27] &&
		!seg_pin_lcd_o[28])
		else $error("fourth common not taken");
	low_pins_a: assert property (seg_pin_lcd_o[25:20] ==
		s_ff.seglo[7:2])
		else $error("lower enable wrong");
	polarity_a: assert property (half_tick |=> s_ff.pol != $past(s_ff.pol)
		##1 $stable(s_ff.pol) || $past(half_tick))
		else $error("polarity not flipped");
	// A mux change may leave the index high for one cycle
	com_range_a: assert property (!$past(reset_i) && $stable(mux) |->
		s_ff.com_drive != 4'h0 &&
		s_ff.com_idx <= (mux[1] ? mux : 2'h1))
		else $error("common index out of range");
	blank_a: assert property (!disp_on |=> s_ff.seg_drive == '0)
		else $error("display not blanked");
	soft_blink_a: assert property (blink_en && !scroll_on &&
		mode == slcd_pkg::BLK_SOFT_OFF |-> !disp_on)
		else $error("software blink ignored");
	scroll_step_a: assert property (scroll_on && blink_exp && auto_blink
		|=> s_ff.scroll_scr == $past(s_ff.scroll_scr) + 2'h1)
		else $error("scroll did not advance");
	ptr_cover_c: cover property (ptr_wr && sfr_i.wdata[7]);
	read_cover_c: cover property (ptr_wr && !sfr_i.wdata[7]);
	scroll_cover_c: cover property (scroll_on && blink_exp && auto_blink);
	blink_cover_c: cover property (s_ff.blink == slcd_pkg::BLK_HIDE);
endmodule
`default_nettype wire

// ### slcd_glass.sv
// Passive model of multiplexed segment glass: per-common images, timing.
// Assumes one-hot common drive and segment drive settled within a step.
`default_nettype none
module slcd_glass (
	input wire logic clock_i,
	input wire logic [slcd_pkg::SEG_LINES-1:0] seg_i,
	input wire logic [slcd_pkg::COMS-1:0] com_i,
	input wire logic pol_i,
	output logic [slcd_pkg::COMS-1:0][slcd_pkg::SEG_LINES-1:0] image_o,
	output logic [15:0] half_o,
	output logic [15:0] step_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [slcd_pkg::COMS-1:0] com_q = '0;
	logic pol_q = 1'b0;
	logic [15:0] hc = '0;
	logic [15:0] sc = '0;
	initial begin
		image_o = '0;
		half_o = '0;
		step_o = '0;
	end
	always @(posedge clock_i) begin
		com_q <= com_i;
		pol_q <= pol_i;
		hc <= hc + 16'h0001;
		sc <= sc + 16'h0001;
		for (int c = 0; c < slcd_pkg::COMS; c++) begin
			// Only a common held for two cycles charges its image
			if (com_i[c] && com_i == com_q) begin
				image_o[c] <= seg_i;
			end
		end
		if (pol_i != pol_q) begin
			half_o <= hc + 16'h0001;
			hc <= '0;
		end
		if (com_i != com_q) begin
			step_o <= sc + 16'h0001;
			sc <= '0;
		end
	end
endmodule
`default_nettype wire

// ### slcd_ctrl_bench.sv
// Self-checking bench of the segment LCD controller with a glass model.
// Assumes shortened prescalers; all drives land 1 ns after a rising edge.
`default_nettype none
module slcd_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_i;
	logic reset_i;
	slcd_pkg::slcd_sfr_t sfr;
	logic [7:0] rdata;
	logic [28:0] seg_pin;
	logic [28:0] seg_drive;
	logic [3:0] com_pin;
	logic [3:0] com_drive;
	logic polarity;
	logic bias;
	logic [3:0][28:0] image;
	logic [15:0] half_len;
	logic [15:0] step_len;
	logic [7:0] mem [4][15];
	logic [31:0] rng;
	logic [7:0] r;
	logic [7:0] q;
	logic [25:0] en;
	logic [3:0][25:0] old;
	logic seen;
	int n_fail;
	int samples_checked;

	slcd_ctrl #(.FAST_DIV(4), .SLOW_DIV(8)) dut_u (
		.clock_i(clock_i), .reset_i(reset_i), .sfr_i(sfr),
		.sfr_rdata_o(rdata), .seg_pin_lcd_o(seg_pin),
		.com_pin_lcd_o(com_pin), .seg_drive_o(seg_drive),
		.com_drive_o(com_drive), .polarity_o(polarity),
		.bias_sel_o(bias));
	slcd_glass glass_u (.clock_i(clock_i), .seg_i(seg_drive),
		.com_i(com_drive), .pol_i(polarity), .image_o(image),
		.half_o(half_len), .step_o(step_len));

	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end

	task automatic rnd(output logic [7:0] v);
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		v = rng[7:0];
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr.wr = 1'b1;
		sfr.addr = a;
		sfr.wdata = d;
		cyc(1);
		sfr.wr = 1'b0;
		cyc(1);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		sfr.rd = 1'b1;
		sfr.addr = a;
		cyc(1);
		sfr.rd = 1'b0;
		cyc(1);
		v = rdata;
	endtask
	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: byte %h not %h", $time, got, exp);
		end
	endtask
	task automatic check32(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: %h not %h", $time, got, exp);
		end
	endtask
	task automatic mem_wr(input logic [1:0] s, input logic [3:0] a,
		input logic [7:0] d);
		wr(slcd_pkg::ADDR_DATA, d);
		wr(slcd_pkg::ADDR_PTR, {2'h2, s, a});
		if (a < 4'hF) mem[s][a] = d;
	endtask
	task automatic mem_rd(input logic [1:0] s, input logic [3:0] a,
		output logic [7:0] v);
		wr(slcd_pkg::ADDR_PTR, {2'h0, s, a});
		rd(slcd_pkg::ADDR_DATA, v);
	endtask
	function automatic logic [25:0] exp_img(input int s, input int c);
		logic [25:0] v;
		for (int k = 0; k < 26; k++) v[k] = mem[s][k / 2][(k % 2) * 4 + c];
		return v & en;
	endfunction
	task automatic show_check(input int s);
		for (int c = 0; c < 4; c++) check32(image[c][25:0], exp_img(s, c));
	endtask
	task automatic end_of_test;
		$display("checked %0d, failed %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	initial begin
		#400000;
		n_fail++;
		end_of_test();
	end

	initial begin
		sfr = '0;
		reset_i = 1'b1;
		rng = 32'd58315;
		n_fail = 0;
		samples_checked = 0;
		seen = 1'b0;
		for (int s = 0; s < 4; s++) for (int a = 0; a < 15; a++) mem[s][a] = 8'h00;
		cyc(2);
		reset_i = 1'b0;
		rd(slcd_pkg::ADDR_CONFIG, q); check8(q, 8'h00);
		rd(slcd_pkg::ADDR_CLOCK, q); check8(q, 8'h00);
		rd(slcd_pkg::ADDR_DATA, q); check8(q, 8'h00);
		rd(slcd_pkg::ADDR_SEGHI, q); check8(q, 8'h00);
		rd(slcd_pkg::ADDR_SEGLO, q); check8(q, 8'h00);
		wr(8'h00, 8'hFF);
		rd(8'h00, q); check8(q, 8'h00);
		check32(seg_pin[25:0], 32'h0000FFFF);
		check32(com_pin, 32'h3);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			rnd(r);
			rnd(q);
			wr(slcd_pkg::ADDR_SEGHI, r);
			wr(slcd_pkg::ADDR_SEGLO, q);
			check32(seg_pin[25:0], {q[7:2], r[3:0], 16'hFFFF});
			rd(slcd_pkg::ADDR_SEGHI, q); check8(q, r & 8'h0F);
		end
		$display("test enables done");
		for (int m = 0; m < 4; m++) begin
			rnd(r);
			wr(slcd_pkg::ADDR_CONFIG, {5'h0, r[2], m[1:0]});
			check32(com_pin, m[1] ? {m[0], 3'h7} : 32'h3);
			check32(bias, r[2]);
			rd(slcd_pkg::ADDR_CONFIG, q); check8(q, {5'h0, r[2], m[1:0]});
		end
		$display("test mux done");
		for (int i = 0; i < 24; i++) begin
			rnd(r);
			rnd(q);
			mem_wr(r[5:4], r[3:0] % 4'hF, q);
		end
		mem_wr(2'h1, 4'hF, 8'hA5);
		rd(slcd_pkg::ADDR_PTR, q); check8(q, 8'h9F);
		wr(slcd_pkg::ADDR_PTR, 8'hFF);
		rd(slcd_pkg::ADDR_PTR, q); check8(q, 8'hBF);
		for (int s = 0; s < 4; s++) for (int a = 0; a < 16; a++) begin
			mem_rd(s[1:0], a[3:0], q);
			check8(q, a < 15 ? mem[s][a] : 8'h00);
		end
		$display("test memory done");
		wr(slcd_pkg::ADDR_CONFIG, 8'h03);
		wr(slcd_pkg::ADDR_CLOCK, 8'h41);
		wr(slcd_pkg::ADDR_SEGHI, 8'h0F);
		wr(slcd_pkg::ADDR_SEGLO, 8'hFC);
		en = 26'h3FFFFFF;
		wr(slcd_pkg::ADDR_SCREEN, 8'h00);
		cyc(100);
		show_check(0);
		for (int c = 0; c < 4; c++) old[c] = exp_img(0, c);
		wr(slcd_pkg::ADDR_SCREEN, 8'h01);
		mem_wr(2'h0, 4'h0, ~mem[0][0]);
		mem_wr(2'h0, 4'hC, ~mem[0][12]);
		cyc(100);
		for (int c = 0; c < 4; c++) check32(image[c][25:0], old[c]);
		wr(slcd_pkg::ADDR_SCREEN, 8'h00);
		cyc(100);
		show_check(0);
		wr(slcd_pkg::ADDR_SCREEN, 8'h04);
		cyc(100);
		show_check(2);
		$display("test display done");
		for (int f = 0; f < 16; f++) begin
			wr(slcd_pkg::ADDR_CLOCK, 8'h40 | f[7:0]);
			cyc(600);
			check32(half_len, {22'h0, slcd_pkg::FD_HALF_DEF[f], 2'h0});
			check32(step_len, {21'h0, slcd_pkg::FD_HALF_DEF[f], 3'h0});
		end
		wr(slcd_pkg::ADDR_CLOCK, 8'h41);
		wr(slcd_pkg::ADDR_CONFIG, 8'h00);
		cyc(200);
		check32(half_len, 32'd16);
		wr(slcd_pkg::ADDR_CONFIG, 8'h0B);
		cyc(200);
		check32(half_len, 32'd16);
		$display("test timing done");
		wr(slcd_pkg::ADDR_CONFIG, 8'h23);
		wr(slcd_pkg::ADDR_CLOCK, 8'h01);
		cyc(200);
		for (int c = 0; c < 4; c++) check32(image[c][25:0], 32'h0);
		wr(slcd_pkg::ADDR_CLOCK, 8'h41);
		cyc(200);
		show_check(2);
		$display("test blink done");
		wr(slcd_pkg::ADDR_CONFIG, 8'h43);
		rd(slcd_pkg::ADDR_CONFIG, q); check8(q, 8'h03);
		for (int s = 0; s < 4; s++) for (int a = 0; a < 15; a++) mem[s][a] = 8'h00;
		for (int i = 0; i < 6; i++) begin
			rnd(r);
			mem_rd(r[5:4], r[3:0] % 4'hF, q);
			check8(q, 8'h00);
		end
		$display("test clear done");
		mem_wr(2'h1, 4'h0, 8'h0F);
		wr(slcd_pkg::ADDR_SCREEN, 8'h80);
		wr(slcd_pkg::ADDR_CLOCK, 8'hC1);
		wr(slcd_pkg::ADDR_CONFIG, 8'h23);
		for (int i = 0; i < 3000 && !seen; i++) begin
			cyc(1);
			if (seg_drive[0] === 1'b1) seen = 1'b1;
		end
		#1;
		check32(seen, 32'h1);
		$display("test scroll done");
		end_of_test();
	end
endmodule
`default_nettype wire
